// *** src/din_filter.sv ***
`include "io_cond_params.svh"
// one direct input: invert, dead-time, one-shot
module din_filter #(
    parameter int MS_CYCLES = `MS_CYC,
    parameter int SHOT_CYCLES = `ONESHOT_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // synchronised line and setup
    input wire logic line_i,
    input wire logic invert_i,
    input wire logic [7:0] dead_ms_i,
    input wire logic oneshot_i,
    // conditioned result
    output logic on_o
);
    // counters are 16 bits wide; refuse counts they cannot reach
    if (MS_CYCLES < 1 || MS_CYCLES > 65536 ||
        SHOT_CYCLES < 1 || SHOT_CYCLES > 65535) begin : g_bad_count
        $error("din_filter counts out of range");
    end
    logic active;
    logic [15:0] tick;
    logic [7:0] ms;
    logic [15:0] shot;
    logic qual;
    logic qual_d;
    assign active = line_i ^ invert_i;
    // dead-time; ms stops at the setting
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !active) begin
            tick <= 16'h0000;
            ms <= 8'h00;
        end else if (ms < dead_ms_i) begin
            if (tick == 16'(MS_CYCLES - 1)) begin
                tick <= 16'h0000;
                ms <= ms + 8'h01;
            end else begin
                tick <= tick + 16'h0001;
            end
        end
    end
    assign qual = active && (ms >= dead_ms_i);
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !qual) begin
            shot <= 16'h0000;
        end else if (shot != 16'(SHOT_CYCLES)) begin
            shot <= shot + 16'h0001;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            qual_d <= 1'b0;
        end else begin
            qual_d <= qual;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            on_o <= 1'b0;
        end else if (oneshot_i) begin
            on_o <= qual && (shot < 16'(SHOT_CYCLES));
        end else begin
            on_o <= qual;
        end
    end
    // helper: cycles output has been high
    logic [15:0] hi_cnt;
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !on_o) hi_cnt <= 16'h0000;
        else if (hi_cnt != 16'hFFFF) hi_cnt <= hi_cnt + 16'h0001;
    end
    property p_shot_width;
        @(posedge mclk_i) disable iff (!reset_n_i)
        oneshot_i |-> hi_cnt <= 16'(SHOT_CYCLES);
    endproperty
    a_shot_width: assert property (p_shot_width)
        else $error("one-shot pulse too long");
    property p_nodead_follow;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (dead_ms_i == 8'h00 && !oneshot_i && active)[*2]
            |=> on_o;
    endproperty
    a_nodead_follow: assert property (p_nodead_follow)
        else $error("input not passed with zero dead-time");
    property p_off_follow;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !active |=> !on_o;
    endproperty
    a_off_follow: assert property (p_off_follow)
        else $error("output on while line inactive");
    c_shot: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        oneshot_i && $fell(on_o) && qual);
endmodule // din_filter

// *** src/io_cond_params.svh ***
`ifndef IO_COND_PARAMS_SVH
`define IO_COND_PARAMS_SVH

// register byte offsets
`define REG_DIN_FUNC     12'h000
`define REG_DIN_COMP     12'h004
`define REG_DIN_CTRL     12'h008
`define REG_DEAD_BASE    12'h010
`define REG_USR_CFG      12'h030
`define REG_DOUT_CFG     12'h034
`define REG_STATUS       12'h038
`define REG_DIN_STATUS   12'h03C
// field positions
`define CTRL_ONESHOT_LSB 8
`define USR_LSB_WIDTH    16
// reset values
`define DIN_FUNC_RST     32'h0000_0000
`define DEAD_RST         8'h00
// timing, clock at 50 MHz
`define CLK_HZ           50_000_000
`define ONESHOT_US       250
`define ONESHOT_CYC      ((`ONESHOT_US * (`CLK_HZ / 1_000_000)))
`define MS_CYC           (`CLK_HZ / 1000)
`define DEAD_MAX_MS      250

`endif

// *** src/io_cond_pkg.sv ***
package io_cond_pkg;
    // apb request
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;
    // apb answer
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;
    typedef enum logic {op_and, op_or} logic_op_e;
    // one combined output source setup
    typedef struct packed {
        logic [4:0] sel_a;
        logic inv_a;
        logic [4:0] sel_b;
        logic inv_b;
        logic_op_e op;
    } comb_cfg_s;
endpackage

// *** src/io_signal_conditioning.sv ***
// The placing of the registers and register access over APB were left to the implementer.
`include "io_cond_params.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// - two combined internal outputs run beside the direct lines.
// - each combined output picks sources A and B from internal outputs.
// - each source has its own invert applied before combining.
// - a per-output setting chooses AND or OR of the two sources.
// - normal homing-done plus composite zone flag by AND needs both on.
// - each of six inputs has an invert bit, reset 0.
// - each input has an ON dead-time of 0 to 250 ms, reset 0.
// - each input has a one-shot enable, reset 0.
// - each input has a composite function code, reset 0 meaning none.
// - one-shot drops the input 250 us after it turns on.
// - an input is on only after staying active past its dead-time.
// - an on input also drives its composite function signal.
// - a direct output turns on only when its combination holds.
module io_signal_conditioning #(
    parameter int NUM_DIN = 6,
    parameter int NUM_FUNC = 32,
    parameter int MS_CYCLES = `MS_CYC,
    parameter int SHOT_CYCLES = `ONESHOT_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire io_cond_pkg::apb_req_s apb_i,
    output io_cond_pkg::apb_rsp_s apb_o,
    // direct input pins
    input wire logic [NUM_DIN-1:0] din_i,
    // internal output signals, one per function code
    input wire logic [NUM_FUNC-1:0] int_out_i,
    // conditioned input functions to the driver
    output logic [NUM_FUNC-1:0] in_func_o,
    // combined internal outputs and direct output
    output logic [1:0] combined_internal_output_o,
    output logic dout_o
);
    import io_cond_pkg::*;
    // register layout packs six lines and 5-bit codes into one word
    if (NUM_DIN < 1 || NUM_DIN > 6 || NUM_FUNC != 32) begin : g_bad_size
        $error("unsupported input count or function count");
    end
    //////////////////////////////////////////////////////////////////////////
    // settings
    logic [NUM_DIN-1:0][4:0] din_func;
    logic [NUM_DIN-1:0][4:0] din_comp;
    logic [NUM_DIN-1:0] din_inv;
    logic [NUM_DIN-1:0] din_shot;
    logic [NUM_DIN-1:0][7:0] dead_ms;
    comb_cfg_s [1:0] usr_cfg;
    comb_cfg_s dout_cfg;
    logic [NUM_DIN-1:0] s1, s2, din_on;
    logic acc_wr, acc;
    logic [31:0] rd;
    logic rd_err;
    logic [NUM_FUNC-1:0] next_func;

    // apb access phase; answer without wait states
    assign acc = apb_i.psel && apb_i.penable;
    assign acc_wr = acc && apb_i.pwrite;

    function automatic logic pick(input logic [31:0] v, input logic [4:0] s,
                                  input logic inv);
        // code 0 is no function and reads off before the invert
        pick = ((s != 5'h00) && v[s]) ^ inv;
    endfunction
    function automatic logic combine(input logic [31:0] v,
                                     input comb_cfg_s c);
        logic a, b;
        a = pick(v, c.sel_a, c.inv_a);
        b = pick(v, c.sel_b, c.inv_b);
        combine = (c.op == op_and) ? (a & b) : (a | b);
    endfunction
    function automatic logic [7:0] clamp_ms(input logic [7:0] v);
        // dead-time settings above the top are held at the top
        clamp_ms = (v > 8'(`DEAD_MAX_MS)) ? 8'(`DEAD_MAX_MS) : v;
    endfunction

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            din_func <= '0;
            din_comp <= '0;
            din_inv <= '0;
            din_shot <= '0;
            dead_ms <= '0;
            usr_cfg <= '0;
            dout_cfg <= '0;
        end else if (acc_wr) begin
            case (apb_i.paddr)
                `REG_DIN_FUNC: din_func <= apb_i.pwdata[5*NUM_DIN-1:0];
                `REG_DIN_COMP: din_comp <= apb_i.pwdata[5*NUM_DIN-1:0];
                `REG_DIN_CTRL: begin
                    din_inv <= apb_i.pwdata[NUM_DIN-1:0];
                    din_shot <= apb_i.pwdata[`CTRL_ONESHOT_LSB +: NUM_DIN];
                end
                `REG_USR_CFG: usr_cfg <= apb_i.pwdata[2*13-1:0];
                `REG_DOUT_CFG: dout_cfg <= apb_i.pwdata[12:0];
                default: begin
                    for (int i = 0; i < NUM_DIN; i++) begin
                        if (apb_i.paddr == `REG_DEAD_BASE + 12'(4*i))
                            dead_ms[i] <= clamp_ms(apb_i.pwdata[7:0]);
                    end
                end
            endcase
        end
    end

    // read mux
    always_comb begin
        rd = 32'h0000_0000;
        rd_err = 1'b0;
        case (apb_i.paddr)
            `REG_DIN_FUNC: rd[5*NUM_DIN-1:0] = din_func;
            `REG_DIN_COMP: rd[5*NUM_DIN-1:0] = din_comp;
            `REG_DIN_CTRL: begin
                rd[NUM_DIN-1:0] = din_inv;
                rd[`CTRL_ONESHOT_LSB +: NUM_DIN] = din_shot;
            end
            `REG_USR_CFG: rd[25:0] = usr_cfg;
            `REG_DOUT_CFG: rd[12:0] = dout_cfg;
            `REG_STATUS: rd[2:0] = {dout_o, combined_internal_output_o};
            `REG_DIN_STATUS: rd[NUM_DIN-1:0] = din_on;
            default: begin
                rd_err = 1'b1;
                for (int i = 0; i < NUM_DIN; i++) begin
                    if (apb_i.paddr == `REG_DEAD_BASE + 12'(4*i)) begin
                        rd[7:0] = dead_ms[i];
                        rd_err = 1'b0;
                    end
                end
            end
        endcase
    end

    // answer registered; pready rises the cycle after setup
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            apb_o <= '0;
        end else begin
            apb_o.pready <= apb_i.psel && !apb_i.penable;
            apb_o.pslverr <= apb_i.psel && !apb_i.penable && rd_err;
            apb_o.prdata <= rd;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // input path; pins pass two flops first
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            s1 <= '0;
            s2 <= '0;
        end else begin
            s1 <= din_i;
            s2 <= s1;
        end
    end

    for (genvar g = 0; g < NUM_DIN; g++) begin : g_din
        din_filter #(
            .MS_CYCLES(MS_CYCLES),
            .SHOT_CYCLES(SHOT_CYCLES)
        ) u_filt (
            .mclk_i(mclk_i),
            .reset_n_i(reset_n_i),
            .line_i(s2[g]),
            .invert_i(din_inv[g]),
            .dead_ms_i(dead_ms[g]),
            .oneshot_i(din_shot[g]),
            .on_o(din_on[g])
        );
    end

    // route to primary and composite functions
    always_comb begin
        next_func = '0;
        for (int i = 0; i < NUM_DIN; i++) begin
            if (din_on[i]) begin
                next_func[din_func[i]] = 1'b1;
                next_func[din_comp[i]] = 1'b1;
            end
        end
        // code 0 is no function
        next_func[0] = 1'b0;
    end
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            in_func_o <= '0;
        end else begin
            in_func_o <= next_func;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // two combined internal outputs
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            combined_internal_output_o <= 2'b00;
        end else begin
            for (int k = 0; k < 2; k++)
                combined_internal_output_o[k] <=
                    combine(int_out_i, usr_cfg[k]);
        end
    end
    // direct output normal and composite combination
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) dout_o <= 1'b0;
        else dout_o <= combine(int_out_i, dout_cfg);
    end
    //////////////////////////////////////////////////////////////////////////
    // checks
    property p_usr_and;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (usr_cfg[0].op == op_and && $stable(usr_cfg[0]))
            |=> combined_internal_output_o[0] ==
                (pick($past(int_out_i), $past(usr_cfg[0].sel_a),
                      $past(usr_cfg[0].inv_a))
                & pick($past(int_out_i), $past(usr_cfg[0].sel_b),
                       $past(usr_cfg[0].inv_b)));
    endproperty
    a_usr_and: assert property (p_usr_and)
        else $error("combined output and mismatch");
    property p_usr_or;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (usr_cfg[1].op == op_or && usr_cfg[1].sel_a != 5'h00 &&
         !usr_cfg[1].inv_a && int_out_i[usr_cfg[1].sel_a] &&
         $stable(usr_cfg[1])) |=> combined_internal_output_o[1];
    endproperty
    a_usr_or: assert property (p_usr_or)
        else $error("combined output or source ignored");
    property p_dout;
        @(posedge mclk_i) disable iff (!reset_n_i)
        dout_cfg.op == op_and && !dout_cfg.inv_a && !dout_cfg.inv_b &&
        $stable(dout_cfg) && !int_out_i[dout_cfg.sel_b]
            |=> !dout_o;
    endproperty
    a_dout: assert property (p_dout)
        else $error("direct output on with composite off");
    property p_route;
        @(posedge mclk_i) disable iff (!reset_n_i)
        din_on[0] && din_comp[0] != 5'h00 && $stable(din_comp[0])
            |=> in_func_o[$past(din_comp[0])];
    endproperty
    a_route: assert property (p_route)
        else $error("composite function not driven");
    property p_ready;
        @(posedge mclk_i) disable iff (!reset_n_i)
        apb_i.psel && !apb_i.penable |=> apb_o.pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("apb answer missing");
    c_usr0: cover property (@(posedge mclk_i) combined_internal_output_o[0]);
    c_dout: cover property (@(posedge mclk_i) dout_o);
    c_func: cover property (@(posedge mclk_i) |in_func_o);
endmodule // io_signal_conditioning

// *** verif/drv_side_model.sv ***
// far side: external wiring on the direct lines plus the driver core
// that supplies internal output signals; both move only on clock edges
module drv_side_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // levels requested by the bench
    input wire logic [5:0] din_req_i,
    input wire logic [31:0] int_req_i,
    // lines into the block
    output logic [5:0] din_o,
    output logic [31:0] int_out_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // lockout stays closed
    // line 5 carries the lockout input; the bench never sets its one-shot
    // normally closed wiring: line 5 reads ON whatever the bench asks
    always_ff @(posedge mclk_i) begin
        din_o <= din_req_i | 6'h20;
    end

    // core signals are cleared in reset, as the driver core does
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            int_out_o <= '0;
        end else begin
            int_out_o <= int_req_i;
        end
    end
endmodule // drv_side_model

// *** verif/io_signal_conditioning_tb.sv ***
module io_signal_conditioning_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import io_cond_pkg::*;

    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    apb_req_s apb_i = '0;
    apb_rsp_s apb_o;
    logic [5:0] din_req = '0;
    logic [31:0] int_req = '0;
    logic [5:0] din;
    logic [31:0] int_out;
    logic [31:0] in_func;
    logic [1:0] comb;
    logic dout;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic err;
    logic [11:0] regs [11] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014,
        12'h018, 12'h01C, 12'h020, 12'h024, 12'h030, 12'h034};

    // 50 MHz clock
    always #10 mclk_i = ~mclk_i;

    // short counts keep the run brief
    io_signal_conditioning #(.MS_CYCLES(10), .SHOT_CYCLES(5)) uut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .apb_i(apb_i),
        .apb_o(apb_o), .din_i(din), .int_out_i(int_out),
        .in_func_o(in_func), .combined_internal_output_o(comb),
        .dout_o(dout));
    drv_side_model far (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .din_req_i(din_req),
        .int_req_i(int_req), .din_o(din), .int_out_o(int_out));

    ////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk_i);
        apb_i <= '{1'b1, 1'b0, wr, a, d};
        @(posedge mclk_i);
        apb_i.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (apb_o.pready === 1'b1) break;
        end
        rd = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i <= '0;
        if (i == 20) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // bounded wait on a function bit; n counts edges before the one that matched
    task wait_func(input int c, input logic lvl, input int lim,
                   input bit must, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge mclk_i);
            if (in_func[c] === lvl) break;
        end
        if (must && n == lim) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    function automatic logic comb_exp(comb_cfg_s c, logic [31:0] s);
        logic a;
        logic b;
        a = s[c.sel_a] ^ c.inv_a;
        b = s[c.sel_b] ^ c.inv_b;
        return (c.op == op_or) ? (a | b) : (a & b);
    endfunction

    task t_reset;
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0);
            chk("setting reset", 32'h0, rd);
        end
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
    endtask

    // inverted line 0 with a composite code
    task t_route;
        int n;
        apb(1'b1, 12'h000, 32'd4);
        apb(1'b1, 12'h004, 32'd6);
        apb(1'b1, 12'h008, 32'h0000_0001);
        wait_func(4, 1'b1, 12, 1'b1, n);
        chk("composite on", 32'h1, {31'h0, in_func[6]});
        chk("code zero", 32'h0, {31'h0, in_func[0]});
        apb(1'b0, 12'h03C, 32'h0);
        chk("input state", 32'h21, rd);
        din_req <= 6'h01;
        wait_func(4, 1'b0, 12, 1'b1, n);
        chk("composite off", 32'h0, {31'h0, in_func[6]});
        din_req <= 6'h00;
        apb(1'b1, 12'h008, 32'h0);
    endtask

    task t_comb;
        comb_cfg_s c0;
        comb_cfg_s c1;
        comb_cfg_s cd;
        cd = '{5'd7, 1'b0, 5'd9, 1'b0, op_and};
        apb(1'b1, 12'h034, {19'h0, cd});
        for (int p = 0; p < 2; p++) begin
            c0 = '{5'd3, 1'b0, 5'd5, p[0], p[0] ? op_or : op_and};
            c1 = '{5'd3, p[0], 5'd5, ~p[0], p[0] ? op_and : op_or};
            apb(1'b1, 12'h030, {6'h0, c1, c0});
            for (int k = 0; k < 4; k++) begin
                int_req <= {22'h0, k[1], 1'b0, k[0], 1'b0, k[1], 1'b0,
                    k[0], 3'h0};
                repeat (4) @(posedge mclk_i);
                chk("combined", {30'h0, comb_exp(c1, int_req),
                    comb_exp(c0, int_req)}, {30'h0, comb});
                chk("dout", {31'h0, comb_exp(cd, int_req)},
                    {31'h0, dout});
                apb(1'b0, 12'h038, 32'h0);
                chk("status", {29'h0, comb_exp(cd, int_req),
                    comb_exp(c1, int_req), comb_exp(c0, int_req)},
                    rd);
            end
        end
    endtask

    // dead-time of 2 ms is 20 cycles at the shortened ms count
    task t_dead;
        int n;
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_0100);
        apb(1'b1, 12'h014, 32'h0000_00FF);
        apb(1'b0, 12'h014, 32'h0);
        chk("dead clamp", 32'd250, rd);
        apb(1'b1, 12'h014, 32'd2);
        din_req <= 6'h02;
        repeat (10) @(posedge mclk_i);
        din_req <= 6'h00;
        wait_func(8, 1'b1, 30, 1'b0, n);
        chk("glitch", 32'd30, n);
        din_req <= 6'h02;
        wait_func(8, 1'b1, 40, 1'b1, n);
        chk("dead window", 32'h1, {31'h0, n >= 20 && n <= 27});
        din_req <= 6'h00;
        apb(1'b1, 12'h014, 32'h0);
    endtask

    // one-shot on line 2; never on the lockout line 5
    task t_shot;
        int n;
        apb(1'b1, 12'h000, 32'h0000_2800);
        apb(1'b1, 12'h008, 32'h0000_0400);
        apb(1'b0, 12'h008, 32'h0);
        chk("lockout shot", 32'h0, {31'h0, rd[13]});
        din_req <= 6'h04;
        wait_func(10, 1'b1, 12, 1'b1, n);
        wait_func(10, 1'b0, 20, 1'b1, n);
        chk("shot width", 32'd5, n + 1);
        wait_func(10, 1'b1, 10, 1'b0, n);
        chk("shot held off", 32'd10, n);
        din_req <= 6'h00;
    endtask

    initial begin
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_route();
        t_comb();
        t_dead();
        t_shot();
        wrap_up();
    end
endmodule // io_signal_conditioning_tb
